// ### test/tb_top.sv
// Self-checking bench for the endpoint mode and count registers
`timescale 1ns/1ns
`default_nettype none
module tb_top import uemcr_pkg::*;;
	logic sys_clk, arst_n, cfg_five_ep, io_read_instruction, io_write_instruction;
	logic [7:0] io_addr, io_wdata, io_rdata_ff;
	logic eng_upd, eng_acked, eng_crc_ok, eng_rx_toggle, eng_setup_hold;
	logic [2:0] eng_ep;
	logic [1:0] eng_tok;
	logic [5:0] eng_rx_bytes;
	logic [8*NUM_EP-1:0] ep_mode_ff, ep_cnt_ff;
	logic [NUM_EP-1:0] ep_int_ff, stall_in_ff, stall_out_ff;
	logic fifo_a0_wr_block_ff, fifo_b0_wr_block_ff;
	int err_total = 0;
	int n_checks = 0;
	// Rows: address, write data, read-back value
	logic [23:0] rows [9] = '{24'h140909, 24'h132020, 24'h160000, 24'h150000, 24'h440c0c,
		24'h43a0a0, 24'h410000, 24'h12c242, 24'h305500};

	uemcr_regs #(.CNT_W(6)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .cfg_five_ep(cfg_five_ep),
		.io_addr(io_addr), .io_read_instruction(io_read_instruction),
		.io_write_instruction(io_write_instruction), .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff),
		.eng_upd(eng_upd), .eng_ep(eng_ep), .eng_tok(eng_tok), .eng_acked(eng_acked),
		.eng_crc_ok(eng_crc_ok), .eng_rx_toggle(eng_rx_toggle), .eng_rx_bytes(eng_rx_bytes),
		.eng_setup_hold(eng_setup_hold), .ep_mode_ff(ep_mode_ff), .ep_cnt_ff(ep_cnt_ff),
		.ep_int_ff(ep_int_ff), .stall_in_ff(stall_in_ff), .stall_out_ff(stall_out_ff),
		.fifo_a0_wr_block_ff(fifo_a0_wr_block_ff), .fifo_b0_wr_block_ff(fifo_b0_wr_block_ff));

	uemcr_eng_model eng (.sys_clk(sys_clk), .eng_upd(eng_upd), .eng_ep(eng_ep), .eng_tok(eng_tok),
		.eng_acked(eng_acked), .eng_crc_ok(eng_crc_ok), .eng_rx_toggle(eng_rx_toggle),
		.eng_rx_bytes(eng_rx_bytes), .eng_setup_hold(eng_setup_hold));

	// 250 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	function automatic logic [7:0] md(input int i);
		return ep_mode_ff[8*i +: 8];
	endfunction : md

	function automatic logic [7:0] cn(input int i);
		return ep_cnt_ff[8*i +: 8];
	endfunction : cn

	task automatic chk(input logic [79:0] seen, exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask : tick

	// One strobe cycle, then a quiet cycle so strobes never re-rise in one step
	task automatic io(input logic wr, input logic [7:0] a, d);
		{io_write_instruction, io_read_instruction, io_addr, io_wdata} = {wr, !wr, a, d};
		tick;
		{io_write_instruction, io_read_instruction} = 2'h0;
		tick;
	endtask : io

	task automatic rd(input logic [7:0] a, exp);
		io(1'b0, a, 8'h00);
		chk(io_rdata_ff, exp, "read data");
	endtask : rd

	task automatic print_verdict;
		if (err_total == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	// Hang guard
	initial begin
		#100000;
		err_total++;
		print_verdict;
	end

	// Main sequence
	initial begin
		{arst_n, cfg_five_ep, io_read_instruction, io_write_instruction, io_addr, io_wdata} = '0;
		repeat (4) @(posedge sys_clk);
		#1;
		arst_n = 1'b1;
		chk({ep_mode_ff, ep_cnt_ff}, 80'h0, "after reset");
		foreach (rows[i]) begin
			io(1'b1, rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		// A0: OUT beats a same-edge write, then locks
		io(1'b1, OFS_A0_MODE, 8'h0b);
		fork
			eng.upd(EP_A0, TOK_OUT, 1'b1, 1'b1, 1'b1, 6'h08);
			io(1'b1, OFS_A0_MODE, 8'h00);
		join
		chk({cn(0), md(0)}, 16'hca3a, "a0 out");
		io(1'b1, OFS_A0_MODE, 8'h01);
		io(1'b1, OFS_A0_CNT, 8'h05);
		chk({cn(0), md(0)}, 16'hca3a, "a0 locked");
		// A read on the update edge leaves the lock on
		fork
			eng.upd(EP_A0, TOK_IN, 1'b1, 1'b1, 1'b0, 6'h00);
			io(1'b0, OFS_A0_MODE, 8'h00);
		join
		io(1'b1, OFS_A0_MODE, 8'h01);
		chk(md(0), 8'h5a, "a0 in");
		rd(OFS_A0_MODE, 8'h5a);
		rd(OFS_A0_CNT, 8'hca);
		io(1'b1, OFS_A0_MODE, 8'h01);
		io(1'b1, OFS_A0_CNT, 8'h05);
		chk({cn(0), md(0)}, 16'h0501, "a0 unlocked");
		// A0 SETUP: flag forced, FIFO writes blocked, then NAK in/out
		eng.hold(EP_A0);
		tick;
		chk({fifo_a0_wr_block_ff, md(0)}, 9'h181, "a0 hold");
		eng.upd(EP_A0, TOK_SETUP, 1'b1, 1'b1, 1'b0, 6'h08);
		chk({ep_int_ff[0], cn(0), md(0)}, 17'h14a91, "a0 setup");
		// A1: bad CRC, then full-size OUT; no lock
		eng.upd(3'h1, TOK_OUT, 1'b0, 1'b0, 1'b0, 6'h04);
		chk({ep_int_ff, cn(1), md(1)}, 21'h020609, "a1 bad crc");
		tick;
		eng.upd(3'h1, TOK_OUT, 1'b1, 1'b1, 1'b1, 6'h20);
		chk({cn(1), md(1)}, 16'he218, "a1 ack");
		io(1'b1, OFS_A1_MODE, 8'h8d);
		chk({stall_in_ff[1], stall_out_ff[1], md(1)}, 10'h18d, "a1 stall in mode");
		io(1'b1, OFS_A1_MODE, 8'h89);
		chk({stall_in_ff[1], stall_out_ff[1]}, 2'h2, "a1 stall out mode");
		// A2 disabled: traffic ignored
		eng.upd(3'h2, TOK_OUT, 1'b1, 1'b1, 1'b1, 6'h08);
		chk({ep_int_ff[2], cn(2), md(2)}, 17'h0, "a2 off");
		// B0 SETUP: flag forced in data phase, FIFO writes blocked
		io(1'b1, OFS_B0_MODE, 8'h0b);
		eng.hold(EP_B0);
		tick;
		io(1'b1, OFS_B0_MODE, 8'h0b);
		chk({fifo_b0_wr_block_ff, md(3)}, 9'h18b, "b0 hold");
		eng.upd(EP_B0, TOK_SETUP, 1'b1, 1'b1, 1'b0, 6'h08);
		chk({cn(3), md(3)}, 16'h4a91, "b0 setup");
		rd(OFS_B0_MODE, 8'h91);
		io(1'b1, OFS_B0_MODE, 8'h02);
		chk({fifo_b0_wr_block_ff, md(3)}, 9'h002, "b0 cleared");
		// Five-endpoint arrangement: 0x42 acts as a data endpoint
		cfg_five_ep = 1'b1;
		io(1'b1, OFS_B0_MODE, 8'h09);
		eng.upd(EP_B0, TOK_OUT, 1'b1, 1'b1, 1'b0, 6'h02);
		chk(md(3), 8'h18, "ep3 ack");
		io(1'b1, OFS_B0_MODE, 8'h0d);
		chk(md(3), 8'h0d, "ep3 unlocked");
		// Second reset in mid-run
		arst_n = 1'b0;
		#1;
		chk({ep_mode_ff, ep_cnt_ff}, 80'h0, "mid reset");
		tick;
		arst_n = 1'b1;
		// Reset also dropped the A0 lock left by the SETUP
		io(1'b1, OFS_A0_MODE, 8'h05);
		rd(OFS_A0_MODE, 8'h05);
		print_verdict;
	end
endmodule : tb_top
`default_nettype wire

// ### test/uemcr_eng_model.sv
// Protocol engine stand-in: update pulses and the SETUP hold level
`timescale 1ns/1ns
`default_nettype none
module uemcr_eng_model (
	input wire logic sys_clk,
	output logic eng_upd,
	output logic [2:0] eng_ep,
	output logic [1:0] eng_tok,
	output logic eng_acked,
	output logic eng_crc_ok,
	output logic eng_rx_toggle,
	output logic [5:0] eng_rx_bytes,
	output logic eng_setup_hold
);
	// Idle from time zero
	initial begin
		{eng_upd, eng_ep, eng_tok, eng_acked, eng_crc_ok, eng_rx_toggle, eng_rx_bytes, eng_setup_hold} = '0;
	end
	// SETUP data phase under way on one endpoint
	task automatic hold(input logic [2:0] ep);
		eng_ep = ep;
		eng_setup_hold = 1'b1;
	endtask : hold
	// Update point of one transaction; the hold ends at the ACK, before it
	task automatic upd(input logic [2:0] ep, input logic [1:0] tok, input logic ack, crc, tog, input logic [5:0] n);
		eng_setup_hold = 1'b0;
		{eng_upd, eng_ep, eng_tok, eng_acked, eng_crc_ok} = {1'b1, ep, tok, ack, crc};
		{eng_rx_toggle, eng_rx_bytes} = {tog, n};
		@(posedge sys_clk);
		#1;
		eng_upd = 1'b0;
		// Payload no longer qualified: never leave the old value showing
		{eng_tok, eng_acked, eng_crc_ok, eng_rx_toggle, eng_rx_bytes} = ~{tok, ack, crc, tog, n};
	endtask : upd
endmodule : uemcr_eng_model
`default_nettype wire

// ### verilog/uemcr_cnt_reg.sv
// One endpoint counter register with engine update and write lock
`timescale 1ns/1ns
`default_nettype none
module uemcr_cnt_reg import uemcr_pkg::*; (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic is_ctrl,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_wdata,
	input wire logic eng_upd,
	input wire logic [7:0] eng_val,
	output logic [7:0] reg_ff,
	output logic lock_ff
);
	// Lock on a received-data update of endpoint zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_ff <= 1'b0;
		end else if (eng_upd && is_ctrl) begin
			lock_ff <= 1'b1;
		end else if (cpu_rd) begin
			lock_ff <= 1'b0;
		end
	end
	// Count value: engine first, then unlocked writes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_ff <= CNT_RST;
		end else if (eng_upd) begin
			reg_ff <= eng_val;
		end else if (cpu_wr && !(is_ctrl && lock_ff)) begin
			reg_ff <= cpu_wdata;
		end
	end
endmodule : uemcr_cnt_reg
`default_nettype wire

// ### verilog/uemcr_mode_reg.sv
// One endpoint mode register with engine update, write lock and SETUP flag
`timescale 1ns/1ns
`default_nettype none
module uemcr_mode_reg import uemcr_pkg::*; (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic is_ctrl,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_wdata,
	input wire logic eng_upd,
	input wire logic [6:0] eng_val,
	input wire logic setup_force,
	output logic [7:0] reg_ff,
	output logic lock_ff
);
	// Lower seven bits and top bit kept apart so each has one writer
	logic [6:0] low_ff;
	logic top_ff;

	// Register value as seen by the bus and the engine
	assign reg_ff = {top_ff, low_ff};

	// Lock after an engine update of a control endpoint, released by a later read
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_ff <= 1'b0;
		end else if (eng_upd && is_ctrl) begin
			lock_ff <= 1'b1;
		end else if (cpu_rd) begin
			lock_ff <= 1'b0;
		end
	end
	// Low seven bits: engine first, then unlocked writes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			low_ff <= MODE_RST[6:0];
		end else if (eng_upd) begin
			low_ff <= eng_val;
		end else if (cpu_wr && !(is_ctrl && lock_ff)) begin
			low_ff <= cpu_wdata[6:0];
		end
	end
	// Top bit: SETUP flag on control endpoints, STALL elsewhere
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			top_ff <= MODE_RST[7];
		end else if (is_ctrl) begin
			if (setup_force) begin
				top_ff <= 1'b1;
			end else if (cpu_wr) begin
				top_ff <= 1'b0;
			end
		end else if (cpu_wr) begin
			top_ff <= cpu_wdata[MB_STALL];
		end
	end
endmodule : uemcr_mode_reg
`default_nettype wire

// ### verilog/uemcr_pkg.sv
// Package of offsets, field positions, reset values and codes for the endpoint mode and count registers
package uemcr_pkg;
	// Register offsets in I/O space
	localparam logic [7:0] OFS_A0_CNT = 8'h11;
	localparam logic [7:0] OFS_A0_MODE = 8'h12;
	localparam logic [7:0] OFS_A1_CNT = 8'h13;
	localparam logic [7:0] OFS_A1_MODE = 8'h14;
	localparam logic [7:0] OFS_A2_CNT = 8'h15;
	localparam logic [7:0] OFS_A2_MODE = 8'h16;
	localparam logic [7:0] OFS_B0_CNT = 8'h41;
	localparam logic [7:0] OFS_B0_MODE = 8'h42;
	localparam logic [7:0] OFS_B1_CNT = 8'h43;
	localparam logic [7:0] OFS_B1_MODE = 8'h44;
	localparam int NUM_EP = 5;
	localparam logic [7:0] MODE_OFS [NUM_EP] = '{OFS_A0_MODE, OFS_A1_MODE, OFS_A2_MODE, OFS_B0_MODE, OFS_B1_MODE};
	localparam logic [7:0] CNT_OFS [NUM_EP] = '{OFS_A0_CNT, OFS_A1_CNT, OFS_A2_CNT, OFS_B0_CNT, OFS_B1_CNT};
	// Endpoint index of the two control endpoints
	localparam logic [2:0] EP_A0 = 3'h0;
	localparam logic [2:0] EP_B0 = 3'h3;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
	// Mode register fields
	localparam int MB_SETUP = 7;
	localparam int MB_STALL = 7;
	localparam int MB_IN = 6;
	localparam int MB_OUT = 5;
	localparam int MB_ACK = 4;
	// Counter register fields
	localparam int CB_TOGGLE = 7;
	localparam int CB_VALID = 6;
	localparam logic [5:0] CRC_BYTES = 6'h02;
	// Mode codes
	localparam logic [3:0] MODE_DISABLE = 4'h0;
	localparam logic [3:0] MODE_NAK_INOUT = 4'h1;
	localparam logic [3:0] MODE_ACK_OUT = 4'h9;
	localparam logic [3:0] MODE_ACK_IN = 4'hd;
	// Tokens reported by the protocol engine
	typedef enum logic [1:0] {
		TOK_NONE = 2'h0,
		TOK_SETUP = 2'h1,
		TOK_OUT = 2'h3,
		TOK_IN = 2'h2
	} uemcr_tok_t;
	// Modes that answer a SETUP token
	function automatic logic uemcr_setup_ok(input logic [3:0] m);
		uemcr_setup_ok = (m inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'ha, 4'hb, 4'he, 4'hf});
	endfunction : uemcr_setup_ok
endpackage : uemcr_pkg

// ### verilog/uemcr_regs.sv
// Endpoint mode and byte-count registers of the full-speed device protocol engine
// How it works
// - Every mode register clears to zero on reset.
// - In five-endpoint mode the 0x42 register acts as non-control endpoint three.
// - ACK bit 4 is set when a transaction ends with an ACK.
// - Control OUT flag bit 5 reports an OUT token; firmware clears it.
// - Control IN flag bit 6 reports an IN token; firmware clears it.
// - Only the engine sets SETUP bit 7; a processor write clears it unless the SETUP hold is active.
// - SETUP flag held high from SETUP data start until ACK start.
// - Engine update locks endpoint-zero mode bits 6:0 until the next read.
// - Mode registers of other endpoints never lock.
// - Endpoint-zero FIFO writes are blocked while SETUP flag is high.
// - STALL stalls OUT in ACK-IN mode and IN in ACK-OUT mode.
// - OUT or SETUP: hardware writes received bytes plus two CRC bytes.
// - Data valid bit 6 follows received CRC; interrupt still occurs on bad CRC.
// - Counter bit 7 is the data toggle; hardware copies received toggle.
// - OUT or SETUP update locks endpoint-zero counter until read.
// - Only a read after the update point, or a reset, unlocks.
// - Update point refreshes mode bits, and counter bits on OUT or SETUP; it raises endpoint interrupt on ACK or on OUT/SETUP bad CRC.
// - Mode 0000 ignores all traffic, except that the SETUP hold still sets bit 7 of a control endpoint; every endpoint starts disabled.
// - An ACK in an ACK mode turns it into the matching NAK mode.
// - A SETUP to a SETUP-accepting mode switches it to 0001.
`timescale 1ns/1ns
`default_nettype none
module uemcr_regs import uemcr_pkg::*; #(
	parameter int CNT_W = 6
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic cfg_five_ep,
	input wire logic [7:0] io_addr,
	input wire logic io_read_instruction,
	input wire logic io_write_instruction,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata_ff,
	input wire logic eng_upd,
	input wire logic [2:0] eng_ep,
	input wire logic [1:0] eng_tok,
	input wire logic eng_acked,
	input wire logic eng_crc_ok,
	input wire logic eng_rx_toggle,
	input wire logic [CNT_W-1:0] eng_rx_bytes,
	input wire logic eng_setup_hold,
	output logic [8*NUM_EP-1:0] ep_mode_ff,
	output logic [8*NUM_EP-1:0] ep_cnt_ff,
	output logic [NUM_EP-1:0] ep_int_ff,
	output logic [NUM_EP-1:0] stall_in_ff,
	output logic [NUM_EP-1:0] stall_out_ff,
	output logic fifo_a0_wr_block_ff,
	output logic fifo_b0_wr_block_ff
);
	logic [7:0] mode_q [NUM_EP];
	logic [7:0] cnt_q [NUM_EP];
	logic [NUM_EP-1:0] mode_lock;
	logic [NUM_EP-1:0] cnt_lock;
	logic [NUM_EP-1:0] is_ctrl;
	logic [NUM_EP-1:0] mode_wr;
	logic [NUM_EP-1:0] mode_rd;
	logic [NUM_EP-1:0] cnt_wr;
	logic [NUM_EP-1:0] cnt_rd;
	logic [NUM_EP-1:0] mode_upd;
	logic [NUM_EP-1:0] cnt_upd;
	logic [NUM_EP-1:0] setup_force;
	logic [NUM_EP-1:0] int_due;
	logic [6:0] mode_val [NUM_EP];
	logic [7:0] cnt_val;
	logic rx_tok;
	logic [7:0] nxt_rdata;

	// Received-data tokens update the counter
	assign rx_tok = (eng_tok == TOK_OUT) || (eng_tok == TOK_SETUP);

	// Counter value written on OUT or SETUP
	assign cnt_val = {eng_rx_toggle, eng_crc_ok, CNT_W'(eng_rx_bytes + CRC_BYTES)};

	// Per-endpoint decode, update values and control identity
	always_comb begin
		for (int i = 0; i < NUM_EP; i++) begin
			is_ctrl[i] = (3'(i) == EP_A0) || ((3'(i) == EP_B0) && !cfg_five_ep);
			mode_wr[i] = io_write_instruction && (io_addr == MODE_OFS[i]);
			mode_rd[i] = io_read_instruction && (io_addr == MODE_OFS[i]);
			cnt_wr[i] = io_write_instruction && (io_addr == CNT_OFS[i]);
			cnt_rd[i] = io_read_instruction && (io_addr == CNT_OFS[i]);
			// Disabled endpoints take no engine update; the SETUP hold still reaches them through setup_force
			mode_upd[i] = eng_upd && (eng_ep == 3'(i)) && (mode_q[i][3:0] != MODE_DISABLE);
			cnt_upd[i] = mode_upd[i] && rx_tok;
			int_due[i] = mode_upd[i] && (eng_acked || (rx_tok && !eng_crc_ok));
			setup_force[i] = eng_setup_hold && (eng_ep == 3'(i)) && is_ctrl[i];
			mode_val[i] = mode_q[i][6:0];
			mode_val[i][MB_ACK] = eng_acked;
			if (is_ctrl[i]) begin
				mode_val[i][MB_IN] = (eng_tok == TOK_IN);
				mode_val[i][MB_OUT] = (eng_tok == TOK_OUT);
			end
			if ((eng_tok == TOK_SETUP) && uemcr_setup_ok(mode_q[i][3:0])) begin
				mode_val[i][3:0] = MODE_NAK_INOUT;
			end else if (eng_acked && mode_q[i][3] && mode_q[i][0]) begin
				mode_val[i][3:0] = {mode_q[i][3:1], 1'b0};
			end
		end
	end

	// One mode and one counter register per endpoint
	for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
		uemcr_mode_reg u_mode (
			.sys_clk(sys_clk),
			.arst_n(arst_n),
			.is_ctrl(is_ctrl[g]),
			.cpu_wr(mode_wr[g]),
			.cpu_rd(mode_rd[g]),
			.cpu_wdata(io_wdata),
			.eng_upd(mode_upd[g]),
			.eng_val(mode_val[g]),
			.setup_force(setup_force[g]),
			.reg_ff(mode_q[g]),
			.lock_ff(mode_lock[g])
		);
		uemcr_cnt_reg u_cnt (
			.sys_clk(sys_clk),
			.arst_n(arst_n),
			.is_ctrl(is_ctrl[g]),
			.cpu_wr(cnt_wr[g]),
			.cpu_rd(cnt_rd[g]),
			.cpu_wdata(io_wdata),
			.eng_upd(cnt_upd[g]),
			.eng_val(cnt_val),
			.reg_ff(cnt_q[g]),
			.lock_ff(cnt_lock[g])
		);
		assign ep_mode_ff[8*g +: 8] = mode_q[g];
		assign ep_cnt_ff[8*g +: 8] = cnt_q[g];
	end

	// Read data select, unmapped addresses read zero
	always_comb begin
		nxt_rdata = RDATA_UNMAPPED;
		for (int i = 0; i < NUM_EP; i++) begin
			if (io_addr == MODE_OFS[i]) begin
				nxt_rdata = mode_q[i];
			end
			if (io_addr == CNT_OFS[i]) begin
				nxt_rdata = cnt_q[i];
			end
		end
	end

	// Read data register, loaded on each read instruction
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			io_rdata_ff <= RDATA_UNMAPPED;
		end else if (io_read_instruction) begin
			io_rdata_ff <= nxt_rdata;
		end
	end

	// Endpoint interrupt flag pulse at the update point
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ep_int_ff <= '0;
		end else begin
			ep_int_ff <= int_due;
		end
	end

	// Stall decisions for non-control endpoints
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stall_in_ff <= '0;
			stall_out_ff <= '0;
		end else begin
			for (int i = 0; i < NUM_EP; i++) begin
				stall_out_ff[i] <= !is_ctrl[i] && mode_q[i][MB_STALL] && (mode_q[i][3:0] == MODE_ACK_IN);
				stall_in_ff[i] <= !is_ctrl[i] && mode_q[i][MB_STALL] && (mode_q[i][3:0] == MODE_ACK_OUT);
			end
		end
	end

	// Endpoint-zero FIFO write block while SETUP is pending
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_a0_wr_block_ff <= 1'b0;
			fifo_b0_wr_block_ff <= 1'b0;
		end else begin
			fifo_a0_wr_block_ff <= setup_force[EP_A0] || mode_q[EP_A0][MB_SETUP];
			fifo_b0_wr_block_ff <= setup_force[EP_B0] || (is_ctrl[EP_B0] && mode_q[EP_B0][MB_SETUP]);
		end
	end

	// Checks on the register file, all on the system clock
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	// Engine update of control endpoint A0 other than a SETUP
	sequence s_a0_update;
		mode_upd[EP_A0] && !(eng_tok == TOK_SETUP);
	endsequence
	// A read of the A0 mode register within eight cycles
	sequence s_a0_read_later;
		##[1:8] (mode_rd[EP_A0] && !mode_upd[EP_A0]);
	endsequence
	// One quiet cycle, then a bare processor write to the A0 mode register
	sequence s_a0_late_write;
		##1 (!mode_rd[EP_A0] && !mode_upd[EP_A0])
		##1 (mode_wr[EP_A0] && !mode_rd[EP_A0] && !mode_upd[EP_A0]);
	endsequence

	// ACK-OUT falls back to NAK-OUT after the ACK
	a_ack_to_nak: assert property (
		(mode_upd[1] && eng_acked && eng_tok != TOK_SETUP && mode_q[1][3:0] == MODE_ACK_OUT)
		|=> mode_q[1][3:0] == 4'h8)
		else $error("ack-out mode did not turn into nak-out");

	// SETUP into an accepting mode forces NAK in/out
	a_setup_to_nak: assert property (
		(mode_upd[EP_A0] && eng_tok == TOK_SETUP && uemcr_setup_ok(mode_q[EP_A0][3:0]))
		|=> mode_q[EP_A0][3:0] == MODE_NAK_INOUT)
		else $error("setup did not force nak in/out mode");

	// Disabled endpoint neither changes nor interrupts
	a_disabled_quiet: assert property (
		(eng_upd && eng_ep == 3'h2 && mode_q[2][3:0] == MODE_DISABLE && !mode_wr[2])
		|=> $stable(mode_q[2]) && !ep_int_ff[2])
		else $error("disabled endpoint reacted to traffic");

	// A processor write outside the SETUP hold drops the SETUP flag
	a_setup_clears: assert property (
		(mode_wr[EP_A0] && !setup_force[EP_A0]) |=> !mode_q[EP_A0][MB_SETUP])
		else $error("cpu write left setup flag set");

	// SETUP flag and FIFO block stand through the data phase
	a_setup_held: assert property (
		setup_force[EP_A0] |=> mode_q[EP_A0][MB_SETUP] && fifo_a0_wr_block_ff)
		else $error("setup flag or fifo block not held");

	// Locked mode bits ignore a write with no read between
	a_lock_holds: assert property (
		s_a0_update ##0 s_a0_late_write |=> $stable(mode_q[EP_A0][6:0]))
		else $error("locked mode bits took a write");

	// A read after the update point releases the lock
	a_read_unlocks: assert property (
		s_a0_update ##0 s_a0_read_later |=> !mode_lock[EP_A0])
		else $error("read after update left lock set");

	// Non-control mode writes land unless an engine update shares the edge
	a_free_nonctrl: assert property (
		(mode_wr[1] && !mode_upd[1]) |=> mode_q[1][6:0] == $past(io_wdata[6:0]))
		else $error("non-control mode write was refused");

	// Received count plus CRC bytes, valid and toggle
	a_count_plus2: assert property (
		cnt_upd[1] |=> cnt_q[1][5:0] == $past(eng_rx_bytes) + 6'h02
		&& cnt_q[1][CB_VALID] == $past(eng_crc_ok) && cnt_q[1][CB_TOGGLE] == $past(eng_rx_toggle))
		else $error("counter update value wrong");

	// Locked counter ignores a write with no read between
	a_cnt_lock: assert property (
		cnt_upd[EP_A0] ##1 (!cnt_rd[EP_A0] && !cnt_upd[EP_A0])[*3]
		##1 (cnt_wr[EP_A0] && !cnt_rd[EP_A0] && !cnt_upd[EP_A0]) |=> $stable(cnt_q[EP_A0]))
		else $error("locked counter took a write");

	// STALL in ACK-IN mode stalls OUT
	a_stall_out: assert property (
		(!is_ctrl[1] && mode_q[1] == 8'h8d) |=> stall_out_ff[1])
		else $error("stall out not raised");

	// Bad CRC still interrupts but clears data valid
	a_int_bad_crc: assert property (
		(mode_upd[1] && rx_tok && !eng_crc_ok) |=> ep_int_ff[1] ##0 !cnt_q[1][CB_VALID])
		else $error("bad crc missed interrupt or kept valid");

	// STALL in ACK-OUT mode stalls IN only
	a_stall_in: assert property (
		(!is_ctrl[1] && mode_q[1] == 8'h89)
		|=> stall_in_ff[1] && !stall_out_ff[1])
		else $error("stall in not raised");

	// Acknowledged transaction raises the endpoint interrupt
	a_int_on_ack: assert property (
		(mode_upd[1] && eng_acked)
		|=> ep_int_ff[1])
		else $error("acked transaction raised no interrupt");

	// Acknowledged transaction sets the ACK bit
	a_ack_flag: assert property (
		(mode_upd[1] && eng_acked)
		|=> mode_q[1][MB_ACK])
		else $error("ack bit not set");

	// OUT token reported on the control endpoint
	a_out_flag: assert property (
		(mode_upd[EP_A0] && eng_tok == TOK_OUT)
		|=> mode_q[EP_A0][MB_OUT] && !mode_q[EP_A0][MB_IN])
		else $error("out token flag wrong");

	// IN token reported on the control endpoint
	a_in_flag: assert property (
		(mode_upd[EP_A0] && eng_tok == TOK_IN)
		|=> mode_q[EP_A0][MB_IN] && !mode_q[EP_A0][MB_OUT])
		else $error("in token flag wrong");

	// Five-endpoint register at 0x42 never locks on update
	a_ep3_no_lock: assert property (
		(cfg_five_ep && mode_upd[EP_B0] && !mode_lock[EP_B0])
		|=> !mode_lock[EP_B0])
		else $error("endpoint three mode register locked");

	// Pending SETUP blocks FIFO writes on both control endpoints
	a_fifo_a0_block: assert property (
		mode_q[EP_A0][MB_SETUP]
		|=> fifo_a0_wr_block_ff)
		else $error("a0 fifo writes not blocked");
	a_fifo_b0_block: assert property (
		(is_ctrl[EP_B0] && mode_q[EP_B0][MB_SETUP])
		|=> fifo_b0_wr_block_ff)
		else $error("b0 fifo writes not blocked");

	// Non-control counters take writes unless an engine update shares the edge
	a_cnt_free: assert property (
		(cnt_wr[1] && !cnt_upd[1])
		|=> cnt_q[1] == $past(io_wdata))
		else $error("non-control counter write was refused");

	// IN update leaves the counter alone
	a_in_no_count: assert property (
		(mode_upd[EP_A0] && eng_tok == TOK_IN && !cnt_wr[EP_A0])
		|=> $stable(cnt_q[EP_A0]))
		else $error("in transaction changed the counter");

	// Update point leaves the SETUP bit as it was
	a_setup_kept: assert property (
		(mode_upd[EP_A0] && !setup_force[EP_A0] && !mode_wr[EP_A0])
		|=> mode_q[EP_A0][MB_SETUP] == $past(mode_q[EP_A0][MB_SETUP]))
		else $error("update changed the setup bit");
endmodule : uemcr_regs
`default_nettype wire
